// [hw/lvdsl_link_top.sv]
// Transmitter serializer and receiver output stage of the 28-bit link
//
// Notes on behaviour
// - Transmitter takes the 28-bit word at each rising strobe edge.
// - Transmitter sends the word on four differential data lanes.
// - Transmitter sends a forwarded clock on its own differential pair.
// - Transmitter sleep low turns off every output driver.
// - Receiver takes four differential data lanes.
// - Receiver frames the data on the forwarded clock's rising edge.
// - Receiver presents the recovered word on 28 parallel outputs.
// - Receiver strobe clock rising edge marks valid parallel data.
// - Receiver sleep low forces every receiver output low.
// - Link uses five pairs: four data, one clock.
// - Each lane carries seven bits per word period.
// - Floating lanes give all ones; lost clock holds data, clock high.
`timescale 1ns/1ps

module lvdsl_link_top (
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        link_bit_clock_in,
  // Transmitter
  input  wire logic [lvdsl_pkg::WORD_W-1:0] parallel_word_in,
  input  wire logic                        parallel_strobe_clock_in,
  input  wire logic                        tx_sleep_n_in,
  output lvdsl_pkg::lvdsl_lanes_t          serial_lane_out,
  output logic [lvdsl_pkg::LANES-1:0]      serial_lane_oe_out,
  output lvdsl_pkg::lvdsl_pair_t           forwarded_link_clock_out,
  output logic                             forwarded_link_clock_oe_out,
  // Receiver
  input  wire lvdsl_pkg::lvdsl_lanes_t     serial_lane_in,
  input  wire lvdsl_pkg::lvdsl_pair_t      forwarded_link_clock_in,
  input  wire logic                        rx_sleep_n_in,
  output logic [lvdsl_pkg::WORD_W-1:0]     parallel_word_out,
  output logic                             recovered_strobe_clock_out
);

  // ==========================================================
  // Transmitter pin synchronisers
  logic [lvdsl_pkg::WORD_W-1:0]    txd1_ff;
  logic [lvdsl_pkg::WORD_W-1:0]    txd2_ff;
  logic                            stb1_ff;
  logic                            stb2_ff;
  logic                            stb3_ff;
  logic                            tslp1_ff;
  logic                            tslp2_ff;
  logic                            stb_rise;

  // Data and strobe share the same delay, so the word seen at the
  // detected edge is the one on the pins at the strobe edge.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      txd1_ff  <= lvdsl_pkg::WORD_RST;
      txd2_ff  <= lvdsl_pkg::WORD_RST;
      stb1_ff  <= 1'b0;
      stb2_ff  <= 1'b0;
      stb3_ff  <= 1'b0;
      tslp1_ff <= 1'b0;
      tslp2_ff <= 1'b0;
    end else begin
      txd1_ff  <= parallel_word_in;
      txd2_ff  <= txd1_ff;
      stb1_ff  <= parallel_strobe_clock_in;
      stb2_ff  <= stb1_ff;
      stb3_ff  <= stb2_ff;
      tslp1_ff <= tx_sleep_n_in;
      tslp2_ff <= tslp1_ff;
    end
  end

  assign stb_rise = stb2_ff & ~stb3_ff;

  // ==========================================================
  // Transmitter control and serializer
  lvdsl_pkg::lvdsl_tx_state_t      tx_state_ff;
  lvdsl_pkg::lvdsl_tx_state_t      nxt_tx_state;
  logic [lvdsl_pkg::WORD_W-1:0]    pend_ff;
  logic [lvdsl_pkg::WORD_W-1:0]    nxt_pend;
  logic [lvdsl_pkg::WORD_W-1:0]    cur_ff;
  logic [lvdsl_pkg::WORD_W-1:0]    nxt_cur;
  logic [2:0]                      tslot_ff;
  logic [2:0]                      nxt_tslot;
  logic [lvdsl_pkg::LANES-1:0]     lane_bit_ff;
  logic [lvdsl_pkg::LANES-1:0]     nxt_lane_bit;
  logic                            fclk_ff;
  logic                            nxt_fclk;
  logic                            toe_ff;
  logic                            nxt_toe;

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_pend     = pend_ff;
    nxt_cur      = cur_ff;
    nxt_tslot    = tslot_ff;
    nxt_toe      = 1'b0;
    if (stb_rise) begin
      nxt_pend = txd2_ff;
    end
    case (tx_state_ff)
      lvdsl_pkg::LVDSL_TX_OFF: begin
        nxt_tslot = lvdsl_pkg::FIRST_SLOT;
        if (tslp2_ff) begin
          nxt_tx_state = lvdsl_pkg::LVDSL_TX_WAIT;
        end
      end
      lvdsl_pkg::LVDSL_TX_WAIT: begin
        // Start only once a strobe edge proves the input clock runs
        nxt_tslot = lvdsl_pkg::FIRST_SLOT;
        if (!tslp2_ff) begin
          nxt_tx_state = lvdsl_pkg::LVDSL_TX_OFF;
        end else if (stb_rise) begin
          nxt_tx_state = lvdsl_pkg::LVDSL_TX_RUN;
          nxt_cur      = txd2_ff;
          nxt_toe      = 1'b1;
        end
      end
      lvdsl_pkg::LVDSL_TX_RUN: begin
        if (!tslp2_ff) begin
          nxt_tx_state = lvdsl_pkg::LVDSL_TX_OFF;
          nxt_tslot    = lvdsl_pkg::FIRST_SLOT;
        end else begin
          nxt_toe = 1'b1;
          if (tslot_ff == lvdsl_pkg::LAST_SLOT) begin
            // Latest word starts at the frame boundary; a slow strobe
            // simply repeats the last word.
            nxt_tslot = lvdsl_pkg::FIRST_SLOT;
            nxt_cur   = nxt_pend;
          end else begin
            nxt_tslot = tslot_ff + 3'h1;
          end
        end
      end
      default: begin
        nxt_tx_state = lvdsl_pkg::LVDSL_TX_OFF;
      end
    endcase
    for (int l = 0; l < lvdsl_pkg::LANES; l++) begin
      nxt_lane_bit[l] = nxt_cur[l*lvdsl_pkg::SLOTS + int'(nxt_tslot)];
    end
    nxt_fclk = lvdsl_pkg::FWD_CLK_PAT[nxt_tslot] & nxt_toe;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_state_ff <= lvdsl_pkg::LVDSL_TX_OFF;
      pend_ff     <= lvdsl_pkg::WORD_RST;
      cur_ff      <= lvdsl_pkg::WORD_RST;
      tslot_ff    <= lvdsl_pkg::FIRST_SLOT;
      lane_bit_ff <= 4'h0;
      fclk_ff     <= 1'b0;
      toe_ff      <= 1'b0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      pend_ff     <= nxt_pend;
      cur_ff      <= nxt_cur;
      tslot_ff    <= nxt_tslot;
      lane_bit_ff <= nxt_lane_bit;
      fclk_ff     <= nxt_fclk;
      toe_ff      <= nxt_toe;
    end
  end

  // Five pairs leave the transmitter: four data and one clock
  assign serial_lane_out.p           = lane_bit_ff;
  assign serial_lane_out.n           = ~lane_bit_ff;
  assign serial_lane_oe_out          = {lvdsl_pkg::LANES{toe_ff}};
  assign forwarded_link_clock_out.p  = fclk_ff;
  assign forwarded_link_clock_out.n  = ~fclk_ff;
  assign forwarded_link_clock_oe_out = toe_ff;

  // ==========================================================
  // Receiver deserializer on the link clock
  logic [lvdsl_pkg::WORD_W-1:0]    deser_word;
  logic                            deser_tog;

  lvdsl_rx_deser u_rx_deser (
    .link_bit_clock_in       (link_bit_clock_in),
    .rst_b_in                (rst_b_in),
    .serial_lane_in          (serial_lane_in),
    .forwarded_link_clock_in (forwarded_link_clock_in),
    .sleep_n_in              (rx_sleep_n_in),
    .word_out                (deser_word),
    .word_toggle_out         (deser_tog)
  );

  // ==========================================================
  // Receiver output stage
  logic                            tg1_ff;
  logic                            tg2_ff;
  logic                            tg3_ff;
  logic                            rslp1_ff;
  logic                            rslp2_ff;
  logic                            new_word;
  logic [lvdsl_pkg::WORD_W-1:0]    rword_ff;
  logic [lvdsl_pkg::WORD_W-1:0]    nxt_rword;
  logic                            rclk_ff;
  logic                            nxt_rclk;
  logic [1:0]                      low_cnt_ff;
  logic [1:0]                      nxt_low_cnt;
  logic [7:0]                      loss_cnt_ff;
  logic [7:0]                      nxt_loss_cnt;

  // The word register in the link domain is stable for a whole frame
  // after its toggle, far longer than the synchroniser delay.
  assign new_word = tg2_ff ^ tg3_ff;

  always_comb begin
    nxt_rword    = rword_ff;
    nxt_rclk     = rclk_ff;
    nxt_low_cnt  = low_cnt_ff;
    nxt_loss_cnt = loss_cnt_ff;
    if (!rslp2_ff) begin
      nxt_rword    = lvdsl_pkg::WORD_RST;
      nxt_rclk     = 1'b0;
      nxt_low_cnt  = 2'h0;
      nxt_loss_cnt = 8'h00;
    end else if (new_word) begin
      nxt_rword    = deser_word;
      nxt_rclk     = 1'b0;
      nxt_low_cnt  = lvdsl_pkg::STROBE_LOW_CYC;
      nxt_loss_cnt = 8'h00;
    end else begin
      if (low_cnt_ff != 2'h0) begin
        nxt_low_cnt = low_cnt_ff - 2'h1;
      end else begin
        nxt_rclk = 1'b1;
      end
      if (loss_cnt_ff == lvdsl_pkg::LOSS_CYC) begin
        // No frames: keep the last word, park the strobe high
        nxt_rclk = 1'b1;
      end else begin
        nxt_loss_cnt = loss_cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tg1_ff      <= 1'b0;
      tg2_ff      <= 1'b0;
      tg3_ff      <= 1'b0;
      rslp1_ff    <= 1'b0;
      rslp2_ff    <= 1'b0;
      rword_ff    <= lvdsl_pkg::WORD_RST;
      rclk_ff     <= 1'b0;
      low_cnt_ff  <= 2'h0;
      loss_cnt_ff <= 8'h00;
    end else begin
      tg1_ff      <= deser_tog;
      tg2_ff      <= tg1_ff;
      tg3_ff      <= tg2_ff;
      rslp1_ff    <= rx_sleep_n_in;
      rslp2_ff    <= rslp1_ff;
      rword_ff    <= nxt_rword;
      rclk_ff     <= nxt_rclk;
      low_cnt_ff  <= nxt_low_cnt;
      loss_cnt_ff <= nxt_loss_cnt;
    end
  end

  assign parallel_word_out          = rword_ff;
  assign recovered_strobe_clock_out = rclk_ff;

endmodule : lvdsl_link_top

// [hw/lvdsl_pkg.sv]
// Shared constants and carrier types for the 28-bit serial link
package lvdsl_pkg;

  // ==========================================================
  // Geometry
  localparam int WORD_W = 28;
  localparam int LANES  = 4;
  localparam int SLOTS  = 7;
  localparam logic [2:0] FIRST_SLOT = 3'h0;
  localparam logic [2:0] LAST_SLOT  = 3'h6;

  // Forwarded clock level per slot, bit index is the slot number
  localparam logic [6:0] FWD_CLK_PAT = 7'h0f;

  // Good frames in a row before the receiver trusts the link
  localparam logic [1:0] LOCK_FRAMES = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 28'h0000000;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS  = 20000;
  localparam int LOSS_TIME_NS   = 2000;
  localparam int STROBE_LOW_NS  = 40;
  // Longest wait rounds down
  localparam logic [7:0] LOSS_CYC =
    8'((LOSS_TIME_NS * 1000) / CLK_PERIOD_PS);
  // Least low time rounds up
  localparam logic [1:0] STROBE_LOW_CYC =
    2'((STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ==========================================================
  // Types
  typedef struct packed {
    logic [LANES-1:0] p;
    logic [LANES-1:0] n;
  } lvdsl_lanes_t;

  typedef struct packed {
    logic p;
    logic n;
  } lvdsl_pair_t;

  typedef enum logic [1:0] {
    LVDSL_TX_OFF  = 2'b00,
    LVDSL_TX_WAIT = 2'b01,
    LVDSL_TX_RUN  = 2'b10
  } lvdsl_tx_state_t;

endpackage : lvdsl_pkg

// [hw/lvdsl_rx_deser.sv]
// Receiver deserializer running on the recovered bit clock
`timescale 1ns/1ps

module lvdsl_rx_deser (
  input  wire logic                        link_bit_clock_in,
  input  wire logic                        rst_b_in,
  input  wire lvdsl_pkg::lvdsl_lanes_t     serial_lane_in,
  input  wire lvdsl_pkg::lvdsl_pair_t      forwarded_link_clock_in,
  input  wire logic                        sleep_n_in,
  output logic [lvdsl_pkg::WORD_W-1:0]     word_out,
  output logic                             word_toggle_out
);

  // ==========================================================
  // Input decode and synchronisers
  logic [4:0]                      raw;
  logic [4:0]                      s1_ff;
  logic [4:0]                      s2_ff;
  logic                            slp1_ff;
  logic                            slp2_ff;
  logic                            prev_clk_ff;
  logic                            nxt_prev_clk;
  logic [2:0]                      slot_ff;
  logic [2:0]                      nxt_slot;
  logic [1:0]                      lock_ff;
  logic [1:0]                      nxt_lock;
  logic [3:0][6:0]                 sr_ff;
  logic [3:0][6:0]                 nxt_sr;
  logic [lvdsl_pkg::WORD_W-1:0]    word_ff;
  logic [lvdsl_pkg::WORD_W-1:0]    nxt_word;
  logic                            tog_ff;
  logic                            nxt_tog;
  logic                            rise;

  // Floating or terminated pairs read as high
  always_comb begin
    for (int i = 0; i < lvdsl_pkg::LANES; i++) begin
      raw[i] = (serial_lane_in.p[i] != serial_lane_in.n[i]) ?
               serial_lane_in.p[i] : 1'b1;
    end
    raw[4] = (forwarded_link_clock_in.p != forwarded_link_clock_in.n) ?
             forwarded_link_clock_in.p : 1'b1;
  end

  // ==========================================================
  // Framing, lock and word assembly
  assign rise = s2_ff[4] & ~prev_clk_ff;

  always_comb begin
    nxt_prev_clk = s2_ff[4];
    nxt_slot     = slot_ff;
    nxt_lock     = lock_ff;
    nxt_word     = word_ff;
    nxt_tog      = tog_ff;
    for (int l = 0; l < lvdsl_pkg::LANES; l++) begin
      nxt_sr[l] = {sr_ff[l][5:0], s2_ff[l]};
    end
    if (!slp2_ff) begin
      nxt_slot = lvdsl_pkg::FIRST_SLOT;
      nxt_lock = 2'h0;
    end else if (rise) begin
      // Clock rising edge marks slot zero of a new frame
      nxt_slot = lvdsl_pkg::FIRST_SLOT;
      if (slot_ff == lvdsl_pkg::LAST_SLOT) begin
        if (lock_ff == lvdsl_pkg::LOCK_FRAMES) begin
          for (int l = 0; l < lvdsl_pkg::LANES; l++) begin
            for (int s = 0; s < lvdsl_pkg::SLOTS; s++) begin
              nxt_word[l*lvdsl_pkg::SLOTS+s] = sr_ff[l][6-s];
            end
          end
          nxt_tog = ~tog_ff;
        end else begin
          nxt_lock = lock_ff + 2'h1;
        end
      end else begin
        nxt_lock = 2'h0;
      end
    end else if (slot_ff != lvdsl_pkg::LAST_SLOT) begin
      nxt_slot = slot_ff + 3'h1;
    end else begin
      // Frame longer than seven slots: drop lock
      nxt_lock = 2'h0;
    end
  end

  always_ff @(posedge link_bit_clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // Idle pairs read high; matching that avoids a false clock edge
      s1_ff       <= 5'h1f;
      s2_ff       <= 5'h1f;
      slp1_ff     <= 1'b0;
      slp2_ff     <= 1'b0;
      prev_clk_ff <= 1'b1;
      slot_ff     <= lvdsl_pkg::FIRST_SLOT;
      lock_ff     <= 2'h0;
      sr_ff       <= '0;
      word_ff     <= lvdsl_pkg::WORD_RST;
      tog_ff      <= 1'b0;
    end else begin
      s1_ff       <= raw;
      s2_ff       <= s1_ff;
      slp1_ff     <= sleep_n_in;
      slp2_ff     <= slp1_ff;
      prev_clk_ff <= nxt_prev_clk;
      slot_ff     <= nxt_slot;
      lock_ff     <= nxt_lock;
      sr_ff       <= nxt_sr;
      word_ff     <= nxt_word;
      tog_ff      <= nxt_tog;
    end
  end

  assign word_out        = word_ff;
  assign word_toggle_out = tog_ff;

endmodule : lvdsl_rx_deser

// [test/lvdsl_link_checker.sv]
// Port-level properties of the 28-bit link top
`timescale 1ns/1ps
module lvdsl_link_checker (
  input wire logic                      clk_in,
  input wire logic                      rst_b_in,
  input wire logic                      tx_sleep_n_in,
  input wire logic                      rx_sleep_n_in,
  input wire lvdsl_pkg::lvdsl_lanes_t   serial_lane_out,
  input wire logic [3:0]                serial_lane_oe_out,
  input wire lvdsl_pkg::lvdsl_pair_t    forwarded_link_clock_out,
  input wire logic                      forwarded_link_clock_oe_out,
  input wire logic [27:0]               parallel_word_out,
  input wire logic                      recovered_strobe_clock_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================
  // Cycles since the last publication
  logic [7:0] idle_ff;
  logic [7:0] nxt_idle;
  logic       stb_ff;
  logic       nxt_stb;
  always_comb begin
    nxt_stb  = recovered_strobe_clock_out;
    nxt_idle = (idle_ff == 8'hff) ? idle_ff : idle_ff + 8'h01;
    if (!rx_sleep_n_in || (stb_ff && !recovered_strobe_clock_out)) begin
      nxt_idle = 8'h00;
    end
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idle_ff <= 8'h00;
      stb_ff  <= 1'b0;
    end else begin
      idle_ff <= nxt_idle;
      stb_ff  <= nxt_stb;
    end
  end
  // ==========================================
  // Assertions
  lane_diff_a: assert property (serial_lane_out.n == ~serial_lane_out.p)
    else $error("lane legs not complementary");
  clk_diff_a: assert property (forwarded_link_clock_out.n ==
    ~forwarded_link_clock_out.p) else $error("clock legs not complementary");
  // Sleep may cut a frame short, so those attempts are dropped
  clk_shape_a: assert property (disable iff (!rst_b_in || !tx_sleep_n_in)
    $rose(forwarded_link_clock_out.p) && forwarded_link_clock_oe_out |->
    forwarded_link_clock_out.p[*4] ##1 !forwarded_link_clock_out.p[*3])
    else $error("forwarded clock not four high three low");
  tx_off_a: assert property (!tx_sleep_n_in[*3] |=>
    serial_lane_oe_out == 4'h0 && !forwarded_link_clock_oe_out)
    else $error("transmitter drives while asleep");
  rx_low_a: assert property (!rx_sleep_n_in[*3] |=>
    parallel_word_out == 28'h0 && !recovered_strobe_clock_out)
    else $error("receiver outputs not low while asleep");
  strobe_low_a: assert property (disable iff (!rst_b_in || !rx_sleep_n_in)
    $fell(recovered_strobe_clock_out) |->
    !recovered_strobe_clock_out[*2] ##[1:2] recovered_strobe_clock_out)
    else $error("strobe low time wrong");
  word_chg_a: assert property ($changed(parallel_word_out) |->
    !recovered_strobe_clock_out) else $error("word changed with strobe high");
  rise_hold_a: assert property ($rose(recovered_strobe_clock_out) |->
    $stable(parallel_word_out) && $past(parallel_word_out, 2) ==
    parallel_word_out) else $error("word not settled before strobe rise");
  // A word after a long gap is a fresh publication, not a fault
  loss_hold_a: assert property (idle_ff > 8'h6e &&
    $stable(parallel_word_out) |-> recovered_strobe_clock_out)
    else $error("lost clock does not hold word and strobe high");
endmodule : lvdsl_link_checker

bind lvdsl_link_top lvdsl_link_checker u_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .tx_sleep_n_in(tx_sleep_n_in),
  .rx_sleep_n_in(rx_sleep_n_in), .serial_lane_out(serial_lane_out),
  .serial_lane_oe_out(serial_lane_oe_out),
  .forwarded_link_clock_out(forwarded_link_clock_out),
  .forwarded_link_clock_oe_out(forwarded_link_clock_oe_out),
  .parallel_word_out(parallel_word_out),
  .recovered_strobe_clock_out(recovered_strobe_clock_out)
);

// [test/lvdsl_far_end.sv]
// Far transmitter model feeding the receiver lanes and bit clock
`timescale 1ns/1ps
module lvdsl_far_end (
  output logic                    bit_clk_out,
  output lvdsl_pkg::lvdsl_lanes_t lane_out,
  output lvdsl_pkg::lvdsl_pair_t  fwd_out
);
  // Released pairs rest with both legs high, held by the failsafe bias
  initial begin
    bit_clk_out = 1'b0;
    lane_out    = '1;
    fwd_out     = '1;
  end
  task automatic tick();
    #62.5 bit_clk_out = 1'b1;
    #62.5 bit_clk_out = 1'b0;
  endtask : tick
  task automatic idle(input int n);
    repeat (n) tick();
  endtask : idle
  // Bit clock stands still once the frames are sent
  task automatic send(input logic [27:0] w, input int frames,
                      input logic float_in);
    for (int f = 0; f < frames; f++) begin
      for (int s = 0; s < 7; s++) begin
        for (int l = 0; l < 4; l++) begin
          lane_out.p[l] = float_in | w[l*7+s];
          lane_out.n[l] = float_in | ~w[l*7+s];
        end
        fwd_out.p = lvdsl_pkg::FWD_CLK_PAT[s];
        fwd_out.n = ~lvdsl_pkg::FWD_CLK_PAT[s];
        tick();
      end
    end
    lane_out = '1;
    fwd_out  = '1;
  endtask : send
endmodule : lvdsl_far_end

// [test/tb.sv]
// Self-checking bench for the 28-bit link top
`timescale 1ns/1ps
module tb;
  logic                    clk_in, rst_b_in, bit_clk, par_stb, stb_run;
  logic                    tx_sleep_n, rx_sleep_n, tx_clk_oe, rx_stb;
  logic [27:0]             par_word, rx_word;
  logic [3:0]              tx_oe, tx_wire;
  lvdsl_pkg::lvdsl_lanes_t tx_lanes, rx_lanes;
  lvdsl_pkg::lvdsl_pair_t  tx_clk, rx_clk;
  int                      fails, tests_run, stb_cnt;

  lvdsl_link_top u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .link_bit_clock_in(bit_clk), .parallel_word_in(par_word),
    .parallel_strobe_clock_in(par_stb), .tx_sleep_n_in(tx_sleep_n),
    .serial_lane_out(tx_lanes), .serial_lane_oe_out(tx_oe),
    .forwarded_link_clock_out(tx_clk),
    .forwarded_link_clock_oe_out(tx_clk_oe), .serial_lane_in(rx_lanes),
    .forwarded_link_clock_in(rx_clk), .rx_sleep_n_in(rx_sleep_n),
    .parallel_word_out(rx_word), .recovered_strobe_clock_out(rx_stb));
  lvdsl_far_end u_far (.bit_clk_out(bit_clk), .lane_out(rx_lanes),
    .fwd_out(rx_clk));

  always #10 clk_in = ~clk_in;
  // Level on the wire: an undriven lane floats
  always_comb begin
    for (int l = 0; l < 4; l++) tx_wire[l] = tx_oe[l] ? tx_lanes.p[l] : 1'bz;
  end
  // Strobe clock, 14 cycles a period so every word gets a frame
  always @(posedge clk_in) begin
    if (stb_run) begin
      stb_cnt = (stb_cnt == 13) ? 0 : stb_cnt + 1;
      par_stb <= #1 (stb_cnt < 7);
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk_word(input logic [27:0] got, input logic [27:0] exp,
                          input string msg);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_word
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic grab_tx(output logic [27:0] w);
    int n;
    n = 0;
    w = '0;
    @(negedge clk_in);
    while (tx_clk.p !== 1'b0 && n < 40) begin @(negedge clk_in); n++; end
    while (tx_clk.p !== 1'b1 && n < 40) begin @(negedge clk_in); n++; end
    if (n >= 40) begin
      fails++;
      $display("BAD %0t no forwarded clock", $time);
    end
    for (int s = 0; s < 7; s++) begin
      for (int l = 0; l < 4; l++) w[l*7+s] = tx_lanes.p[l];
      @(negedge clk_in);
    end
  endtask : grab_tx
  // ==========================================
  // Scenarios
  task automatic test_tx();
    logic [27:0] got;
    logic [27:0] pats [3];
    pats = '{28'h5a3c96e, 28'hfffffff, 28'h0000001};
    stb_run = 1'b1;
    cyc(30);
    tx_sleep_n = 1'b1;
    foreach (pats[i]) begin
      par_word = pats[i];
      cyc(40);
      grab_tx(got);
      chk_word(got, pats[i], "tx frame");
    end
    chk_word({24'h0, tx_oe}, 28'h000000f, "lanes enabled");
    chk_word({27'h0, tx_clk_oe}, 28'h0000001, "clock enabled");
    $display("test_tx done");
  endtask : test_tx
  task automatic test_tx_sleep();
    logic [27:0] got;
    cyc(1);
    tx_sleep_n = 1'b0;
    cyc(6);
    chk_word({24'h0, tx_wire}, {24'h0, 4'hz}, "lanes released");
    chk_word({27'h0, tx_clk_oe}, 28'h0, "clock released");
    stb_run = 1'b0;
    cyc(30);
    stb_run = 1'b1;
    cyc(30);
    tx_sleep_n = 1'b1;
    par_word = 28'h2468ace;
    cyc(40);
    grab_tx(got);
    chk_word(got, 28'h2468ace, "tx after wake");
    $display("test_tx_sleep done");
  endtask : test_tx_sleep
  task automatic test_rx();
    u_far.send(28'h9abcdef, 7, 1'b0);
    cyc(20);
    chk_word(rx_word, 28'h9abcdef, "rx word");
    chk_word({27'h0, rx_stb}, 28'h0000001, "rx strobe");
    u_far.send(28'h0f0f0f0, 7, 1'b0);
    cyc(20);
    chk_word(rx_word, 28'h0f0f0f0, "rx next word");
    u_far.send(28'h0000000, 7, 1'b1);
    cyc(20);
    chk_word(rx_word, 28'hfffffff, "rx floating lanes");
    cyc(150);
    chk_word(rx_word, 28'hfffffff, "rx held word");
    chk_word({27'h0, rx_stb}, 28'h0000001, "rx lost clock");
    $display("test_rx done");
  endtask : test_rx
  task automatic test_rx_sleep();
    rx_sleep_n = 1'b0;
    cyc(6);
    chk_word(rx_word, 28'h0, "rx asleep word");
    chk_word({27'h0, rx_stb}, 28'h0, "rx asleep strobe");
    // Let the link side see sleep so its lock is cleared
    u_far.idle(4);
    cyc(1);
    rx_sleep_n = 1'b1;
    u_far.send(28'h1234567, 8, 1'b0);
    cyc(20);
    chk_word(rx_word, 28'h1234567, "rx after wake");
    $display("test_rx_sleep done");
  endtask : test_rx_sleep
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // ==========================================
  // Main sequence and watchdog
  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    par_word = 28'h0;
    par_stb = 1'b0;
    stb_run = 1'b0;
    stb_cnt = 0;
    tx_sleep_n = 1'b0;
    rx_sleep_n = 1'b1;
    fails = 0;
    tests_run = 0;
    fork
      u_far.idle(4);
    join_none
    cyc(12);
    rst_b_in = 1'b1;
    test_tx();
    test_tx_sleep();
    test_rx();
    test_rx_sleep();
    test_done();
  end
  // Whole run is near 40 us; five times that means a hang
  initial begin
    #200000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
endmodule : tb
